/* dcm_defines.svh */
// constants for the debug comms monitor
`ifndef DCM_DEFINES_SVH
`define DCM_DEFINES_SVH
`define DCM_WORD_W        32
`define DCM_STAT_IN_BIT   0
`define DCM_STAT_OUT_BIT  1
`define DCM_STAT_VER_LSB  28
`define DCM_DBG_ABT_BIT   0
`define DCM_CTRL_MON_BIT  4
`define DCM_CTRL_W        6
`define DCM_CTRL_RST      6'h00
`define DCM_VERSION       4'h5
`endif

/* dcm_pkg.sv */
// types shared by the debug comms monitor
package dcm_pkg;
   typedef struct packed {
      logic [31:0] addr;
      logic        user;
      logic        write;
      logic [1:0]  size;
      logic        ext_cond;
   } dcm_access_t;
   typedef struct packed {
      logic        enable;
      logic        is_watch;
      logic [31:0] addr;
      logic [31:0] addr_mask;
      logic        match_user;
      logic        care_user;
      logic        match_write;
      logic        care_write;
      logic [1:0]  match_size;
      logic        care_size;
      logic        match_ext;
      logic        care_ext;
   } dcm_unit_cfg_t;
endpackage : dcm_pkg

/* dcm_pulse_sync.sv */
// toggle crossing for one-cycle events between clock domains
`timescale 1ns/1ps
module dcm_pulse_sync (
   input  wire logic src_clk_in,
   input  wire logic src_rst_in,
   input  wire logic src_pulse_in,
   input  wire logic dst_clk_in,
   input  wire logic dst_rst_in,
   output logic      dst_pulse_out
);
   logic src_tog;
   logic sync1;
   logic sync2;
   logic sync3;
   always_ff @(posedge src_clk_in) begin
      if (src_rst_in) src_tog <= 1'b0;
      else if (src_pulse_in) src_tog <= ~src_tog;
   end
   // first stage only feeds the second
   always_ff @(posedge dst_clk_in) begin
      if (dst_rst_in) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= src_tog;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   always_ff @(posedge dst_clk_in) begin
      if (dst_rst_in) dst_pulse_out <= 1'b0;
      else dst_pulse_out <= sync2 ^ sync3;
   end
endmodule : dcm_pulse_sync

/* dcm_wp_unit.sv */
// one monitor-mode watchpoint/breakpoint comparator
`timescale 1ns/1ps
module dcm_wp_unit
   import dcm_pkg::*;
(
   input  wire logic          sys_clk_in,
   input  wire logic          sys_rst_in,
   input  wire dcm_unit_cfg_t cfg_in,
   input  wire logic          cfg_wr_in,
   input  wire dcm_access_t   iacc_in,
   input  wire logic          ivalid_in,
   input  wire dcm_access_t   dacc_in,
   input  wire logic          dvalid_in,
   output logic              hit_out
);
   logic sel_ok;
   logic hit_now;
   dcm_access_t acc;
   always_comb begin
      acc     = cfg_in.is_watch ? dacc_in : iacc_in;
      sel_ok  = cfg_in.is_watch ? dvalid_in : ivalid_in;
      // address, ext cond, privilege, size and (watchpoints only) direction; no data
      hit_now = cfg_in.enable && sel_ok
         && (((acc.addr ^ cfg_in.addr) & ~cfg_in.addr_mask) == 32'h0000_0000)
         && (!cfg_in.care_user  || acc.user == cfg_in.match_user)
         && (!cfg_in.care_write || !cfg_in.is_watch || acc.write == cfg_in.match_write)
         && (!cfg_in.care_size  || acc.size == cfg_in.match_size)
         && (!cfg_in.care_ext   || acc.ext_cond == cfg_in.match_ext);
   end
   // register update masks this unit's match that cycle
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) hit_out <= 1'b0;
      else hit_out <= hit_now && !cfg_wr_in;
   end
   a_wr_suppress: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      cfg_wr_in |=> !hit_out) else $error("hit during unit write");
   a_disabled_quiet: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !cfg_in.enable |=> !hit_out) else $error("hit from disabled unit");
endmodule : dcm_wp_unit

/* dcm_debug_comms_monitor.sv */
// debug comms mailbox and monitor-mode abort generation
`timescale 1ns/1ps
`include "dcm_defines.svh"
// Functional notes
// - processor write sets outbound pending flag
// - debugger outbound read clears outbound flag
// - both flags visible to debugger and processor
// - debugger inbound write sets inbound flag
// - processor inbound read clears inbound flag
// - control bit 4 selects monitor-mode aborts
// - monitor mode: no data, range, chaining
// - match on address, cond, privilege, size; direction on watchpoints only
// - monitor mode: no single-step, no external match
// - monitor aborts recorded in debug status
// - unit write suppresses its match
// - monitor mode never halts the core
// - status bit1 outbound, bit0 inbound, read-only
// - abort flag skipped when external abort
// - mailbox registers are 32 bits
module dcm_debug_comms_monitor
   import dcm_pkg::*;
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  link_clk_in,
   input  wire logic                  link_rst_in,
   // processor coprocessor transfers
   input  wire logic                  cp_out_wr_in,
   input  wire logic [31:0]           cp_out_data_in,
   input  wire logic                  cp_in_rd_in,
   output logic [31:0]                cp_in_data_out,
   output logic [31:0]                cp_status_out,
   input  wire logic                  cp_dbg_stat_wr_in,
   input  wire logic                  cp_dbg_stat_data_in,
   output logic                       debug_abort_flag_out,
   // debugger side, on the scan clock
   input  wire logic                  jt_out_rd_in,
   output logic [31:0]                jt_out_data_out,
   input  wire logic                  jt_in_wr_in,
   input  wire logic [31:0]           jt_in_data_in,
   output logic [1:0]                 jt_status_out,
   input  wire logic                  jt_ctrl_wr_in,
   input  wire logic [`DCM_CTRL_W-1:0] jt_ctrl_data_in,
   // watchpoint configuration and core accesses
   input  wire dcm_unit_cfg_t         unit0_cfg_in,
   input  wire logic                  unit0_wr_in,
   input  wire dcm_unit_cfg_t         unit1_cfg_in,
   input  wire logic                  unit1_wr_in,
   input  wire dcm_access_t           iacc_in,
   input  wire logic                  ivalid_in,
   input  wire dcm_access_t           dacc_in,
   input  wire logic                  dvalid_in,
   input  wire logic                  external_abort_in,
   input  wire logic                  ext_bkpt_in,
   input  wire logic                  ext_wpt_in,
   input  wire logic                  single_step_req_in,
   output logic                       prefetch_abort_out,
   output logic                       data_abort_out,
   output logic                       halt_req_out,
   output logic                       monitor_mode_out
);
   import dcm_pkg::*;

   // ==========================================================
   // mailbox storage
   logic [`DCM_WORD_W-1:0] out_data;
   logic [`DCM_WORD_W-1:0] in_data;
   logic                   out_pending;
   logic                   in_pending;
   logic                   out_set_lnk;
   logic                   in_clr_lnk;
   logic                   in_set_sys;
   logic                   out_clr_sys;
   logic [1:0]             out_pend_lnk_sync;
   logic [1:0]             in_pend_lnk_sync;
   logic [1:0]             mon_sync;
   logic [`DCM_CTRL_W-1:0] ctrl_lnk;
   logic                   mon_mode;

   // outbound word written on core clock; stable while pending so the
   // link side may read it without a word crossing
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) out_data <= 32'h0000_0000;
      else if (cp_out_wr_in && !out_pending) out_data <= cp_out_data_in;
   end

   // set wins over clear on the same edge
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) out_pending <= 1'b0;
      else if (cp_out_wr_in) out_pending <= 1'b1;
      else if (out_clr_sys) out_pending <= 1'b0;
   end

   // inbound word is written on link clock and held stable while pending
   // limitation: a write before the flag returns to the link side still lands
   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) in_data <= 32'h0000_0000;
      else if (jt_in_wr_in && !in_pend_lnk_sync[1]) in_data <= jt_in_data_in;
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) in_pending <= 1'b0;
      else if (in_set_sys) in_pending <= 1'b1;
      else if (cp_in_rd_in) in_pending <= 1'b0;
   end

   always_comb begin
      out_set_lnk = jt_out_rd_in;
      in_clr_lnk  = jt_in_wr_in && !in_pend_lnk_sync[1];
   end

   dcm_pulse_sync u_out_clr (
      .src_clk_in   (link_clk_in),
      .src_rst_in   (link_rst_in),
      .src_pulse_in (out_set_lnk),
      .dst_clk_in   (sys_clk_in),
      .dst_rst_in   (sys_rst_in),
      .dst_pulse_out(out_clr_sys)
   );

   dcm_pulse_sync u_in_set (
      .src_clk_in   (link_clk_in),
      .src_rst_in   (link_rst_in),
      .src_pulse_in (in_clr_lnk),
      .dst_clk_in   (sys_clk_in),
      .dst_rst_in   (sys_rst_in),
      .dst_pulse_out(in_set_sys)
   );

   // ==========================================================
   // link-side status and data view
   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) begin
         out_pend_lnk_sync <= 2'b00;
         in_pend_lnk_sync  <= 2'b00;
      end else begin
         out_pend_lnk_sync <= {out_pend_lnk_sync[0], out_pending};
         in_pend_lnk_sync  <= {in_pend_lnk_sync[0], in_pending};
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) jt_status_out <= 2'b00;
      else jt_status_out <= {out_pend_lnk_sync[1], in_pend_lnk_sync[1]};
   end

   // debugger only scans out when pending was seen
   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) jt_out_data_out <= 32'h0000_0000;
      else if (out_pend_lnk_sync[1]) jt_out_data_out <= out_data;
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) ctrl_lnk <= `DCM_CTRL_RST;
      else if (jt_ctrl_wr_in) ctrl_lnk <= jt_ctrl_data_in;
   end

   // ==========================================================
   // processor-side status
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) cp_status_out <= 32'h0000_0000;
      else begin
         cp_status_out <= 32'h0000_0000;
         cp_status_out[31:`DCM_STAT_VER_LSB] <= `DCM_VERSION;  // arbitrary version code
         cp_status_out[`DCM_STAT_OUT_BIT] <= out_pending;
         cp_status_out[`DCM_STAT_IN_BIT]  <= in_pending;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) cp_in_data_out <= 32'h0000_0000;
      else if (in_pending) cp_in_data_out <= in_data;
   end

   // ==========================================================
   // monitor mode and aborts
   // control bit is a slow level, so a plain three-flop chain (mon_sync then mon_mode) is enough
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         mon_sync <= 2'b00;
         mon_mode <= 1'b0;
      end else begin
         mon_sync <= {mon_sync[0], ctrl_lnk[`DCM_CTRL_MON_BIT]};
         mon_mode <= mon_sync[1];
      end
   end

   logic hit0;
   logic hit1;
   logic bk_hit;
   logic wp_hit;

   dcm_wp_unit u_unit0 (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .cfg_in     (unit0_cfg_in),
      .cfg_wr_in  (unit0_wr_in),
      .iacc_in    (iacc_in),
      .ivalid_in  (ivalid_in),
      .dacc_in    (dacc_in),
      .dvalid_in  (dvalid_in),
      .hit_out    (hit0)
   );

   dcm_wp_unit u_unit1 (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .cfg_in     (unit1_cfg_in),
      .cfg_wr_in  (unit1_wr_in),
      .iacc_in    (iacc_in),
      .ivalid_in  (ivalid_in),
      .dacc_in    (dacc_in),
      .dvalid_in  (dvalid_in),
      .hit_out    (hit1)
   );

   // external match pins ignored in monitor mode
   always_comb begin
      bk_hit = (hit0 && !unit0_cfg_in.is_watch) || (hit1 && !unit1_cfg_in.is_watch);
      wp_hit = (hit0 && unit0_cfg_in.is_watch) || (hit1 && unit1_cfg_in.is_watch);
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         prefetch_abort_out <= 1'b0;
         data_abort_out     <= 1'b0;
      end else begin
         prefetch_abort_out <= mon_mode && bk_hit;
         data_abort_out     <= mon_mode && wp_hit;
      end
   end

   // halt only in halt mode; single-step and external pins gated off
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) halt_req_out <= 1'b0;
      else halt_req_out <= !mon_mode && (hit0 || hit1 || ext_bkpt_in || ext_wpt_in
                                         || single_step_req_in);
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) monitor_mode_out <= 1'b0;
      else monitor_mode_out <= mon_mode;
   end

   // external abort takes priority over the debug flag
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) debug_abort_flag_out <= 1'b0;
      else if ((prefetch_abort_out || data_abort_out) && !external_abort_in)
         debug_abort_flag_out <= 1'b1;
      else if (cp_dbg_stat_wr_in) debug_abort_flag_out <= cp_dbg_stat_data_in;
   end

   // ==========================================================
   // checks
   a_out_set: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      cp_out_wr_in |=> out_pending) else $error("outbound flag not set");
   a_out_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (out_clr_sys && !cp_out_wr_in) |=> !out_pending) else $error("outbound flag not cleared");
   a_in_set: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      in_set_sys |=> in_pending) else $error("inbound flag not set");
   a_in_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (cp_in_rd_in && !in_set_sys) |=> !in_pending) else $error("inbound flag not cleared");
   a_stat_bits: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      ##1 cp_status_out[1:0] == {$past(out_pending), $past(in_pending)})
      else $error("status bits misplaced");
   a_no_halt_mon: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      mon_mode |=> !halt_req_out) else $error("halt in monitor mode");
   a_bk_abort: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (mon_mode && bk_hit) |=> prefetch_abort_out) else $error("missing prefetch abort");
   a_abt_record: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      ((data_abort_out || prefetch_abort_out) && !external_abort_in) |=> debug_abort_flag_out)
      else $error("abort not recorded");
   a_lnk_status: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
      ##1 jt_status_out == $past({out_pend_lnk_sync[1], in_pend_lnk_sync[1]}))
      else $error("link status wrong");
   // ==========================================================
   // monitor-mode, halt-pin and reserved status checks, and covers
   a_wp_abort: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (mon_mode && wp_hit) |=> data_abort_out) else $error("missing data abort");
   a_abort_mon_only: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !mon_mode |=> !(prefetch_abort_out || data_abort_out)) else $error("abort outside monitor mode");
   a_ext_abt_skip: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      ((prefetch_abort_out || data_abort_out) && external_abort_in && !cp_dbg_stat_wr_in
       && !debug_abort_flag_out) |=> !debug_abort_flag_out) else $error("flag set on external abort");
   a_stat_reserved: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      cp_status_out[27:2] == 26'h0) else $error("reserved status bits set");
   a_halt_pins: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (!mon_mode && (ext_bkpt_in || ext_wpt_in || single_step_req_in)) |=> halt_req_out)
      else $error("halt mode pin ignored");
   c_out_trip: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      cp_out_wr_in ##[1:40] out_clr_sys);
   c_in_trip: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      in_set_sys ##[1:40] cp_in_rd_in);
   c_pf_abort: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) prefetch_abort_out);
   c_dt_abort: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) data_abort_out);
   c_ext_abort: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      data_abort_out && external_abort_in);
endmodule : dcm_debug_comms_monitor

/* dcm_host_model.sv */
// host debugger model on the scan side of the mailbox
`timescale 1ns/1ps
module dcm_host_model (
   input  wire logic        link_clk_in,
   input  wire logic        link_rst_in,
   input  wire logic [1:0]  status_in,
   input  wire logic [31:0] out_data_in,
   input  wire logic        slow_in,
   input  wire logic        send_tog_in,
   input  wire logic [31:0] send_word_in,
   output logic             out_rd_out,
   output logic             in_wr_out,
   output logic [31:0]      in_data_out,
   output logic [31:0]      rx_word_out,
   output logic [15:0]      rx_count_out
);
   // =====================================
   // polling engine
   logic [3:0] guard;
   logic       sent_tog;
   // guard covers the flag round trip, so a stale flag is never acted on twice
   always_ff @(posedge link_clk_in) begin
      out_rd_out <= 1'b0;
      in_wr_out  <= 1'b0;
      if (link_rst_in) begin
         guard        <= 4'h0;
         sent_tog     <= 1'b0;
         rx_count_out <= 16'h0;
         rx_word_out  <= 32'h0;
         in_data_out  <= 32'h0;
      end else if (guard != 4'h0) begin
         guard       <= guard - 4'h1;
         in_data_out <= ~in_data_out;
      end else if (status_in[1] && !slow_in) begin
         out_rd_out   <= 1'b1;
         rx_word_out  <= out_data_in;
         rx_count_out <= rx_count_out + 16'h1;
         guard        <= 4'hf;
      end else if (sent_tog != send_tog_in && !status_in[0]) begin
         in_wr_out   <= 1'b1;
         in_data_out <= send_word_in;
         sent_tog    <= send_tog_in;
         guard       <= 4'hf;
      end else begin
         in_data_out <= ~in_data_out;
      end
   end
   // never asks for a halt or an abort vector catch
endmodule : dcm_host_model

/* dcm_debug_comms_monitor_tb_top.sv */
// self-checking bench for the debug comms monitor
`timescale 1ns/1ps
`include "dcm_defines.svh"
module dcm_debug_comms_monitor_tb_top;
   import dcm_pkg::*;
   // =====================================
   // stimulus and observed signals
   logic          sys_clk = 1'b0;
   logic          link_clk = 1'b0;
   logic          rst = 1'b1;
   logic          out_wr = 1'b0;
   logic [31:0]   out_data = 32'h0;
   logic          in_rd = 1'b0;
   logic          st_wr = 1'b0;
   logic          st_d = 1'b0;
   logic          ctrl_wr = 1'b0;
   logic [5:0]    ctrl_d = 6'h0;
   dcm_unit_cfg_t u0_cfg = '0;
   dcm_unit_cfg_t u1_cfg = '0;
   logic          u0_wr = 1'b0;
   logic          u1_wr = 1'b0;
   dcm_access_t   iacc = '0;
   dcm_access_t   dacc = '0;
   logic          ivalid = 1'b0;
   logic          dvalid = 1'b0;
   logic          ext_abt = 1'b0;
   logic [2:0]    pins = 3'b000;
   logic          slow = 1'b0;
   logic          send_tog = 1'b0;
   logic [31:0]   send_word = 32'h0;
   logic [31:0]   in_data, cp_status, jt_out_data, jt_in_data, rx_word, r, w, ba, wa;
   logic [1:0]    jt_status;
   logic          abt_flag, jt_out_rd, jt_in_wr, pabt, dabt, halt, mon;
   logic [15:0]   rx_count, rx_exp;
   logic [2:0]    seen = 3'b000;
   dcm_unit_cfg_t c;
   int            fail_count = 0;
   int            checked = 0;
   int            k;
   always #2.5 sys_clk = ~sys_clk;
   initial begin
      #1.3;
      forever #7.5 link_clk = ~link_clk;
   end
   // aborts are one-cycle pulses and halts last only while the pins are held, so they are gathered here
   always @(posedge sys_clk) seen <= seen | {halt, dabt, pabt};
   dcm_debug_comms_monitor dcm_debug_comms_monitor_inst (
      .sys_clk_in(sys_clk), .sys_rst_in(rst), .link_clk_in(link_clk), .link_rst_in(rst),
      .cp_out_wr_in(out_wr), .cp_out_data_in(out_data), .cp_in_rd_in(in_rd),
      .cp_in_data_out(in_data), .cp_status_out(cp_status), .cp_dbg_stat_wr_in(st_wr),
      .cp_dbg_stat_data_in(st_d), .debug_abort_flag_out(abt_flag), .jt_out_rd_in(jt_out_rd),
      .jt_out_data_out(jt_out_data), .jt_in_wr_in(jt_in_wr), .jt_in_data_in(jt_in_data),
      .jt_status_out(jt_status), .jt_ctrl_wr_in(ctrl_wr), .jt_ctrl_data_in(ctrl_d),
      .unit0_cfg_in(u0_cfg), .unit0_wr_in(u0_wr), .unit1_cfg_in(u1_cfg), .unit1_wr_in(u1_wr),
      .iacc_in(iacc), .ivalid_in(ivalid), .dacc_in(dacc), .dvalid_in(dvalid),
      .external_abort_in(ext_abt), .ext_bkpt_in(pins[2]), .ext_wpt_in(pins[1]),
      .single_step_req_in(pins[0]), .prefetch_abort_out(pabt), .data_abort_out(dabt),
      .halt_req_out(halt), .monitor_mode_out(mon));
   dcm_host_model dcm_host_model_inst (
      .link_clk_in(link_clk), .link_rst_in(rst), .status_in(jt_status),
      .out_data_in(jt_out_data), .slow_in(slow), .send_tog_in(send_tog),
      .send_word_in(send_word), .out_rd_out(jt_out_rd), .in_wr_out(jt_in_wr),
      .in_data_out(jt_in_data), .rx_word_out(rx_word), .rx_count_out(rx_count));
   // =====================================
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   function automatic logic pick(input int s);
      case (s)
         0: return cp_status[0];
         1: return cp_status[1];
         2: return jt_status[0];
         3: return jt_status[1];
         4: return mon;
         default: return logic'(rx_count === rx_exp);
      endcase
   endfunction : pick
   task automatic complete_run();
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask : chk_word
   task automatic chk_bit(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s expected %b seen %b", n, e, g);
         fail_count++;
      end
   endtask : chk_bit
   task automatic sy(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : sy
   task automatic wait_for(input int s, input logic v);
      int i;
      for (i = 0; i < 300 && pick(s) !== v; i++) sy(1);
      chk_bit("wait", v, pick(s));
      if (i == 300) complete_run();
   endtask : wait_for
   task automatic prog(input logic u, input dcm_unit_cfg_t x);
      if (u) u1_cfg = x;
      else u0_cfg = x;
      {u1_wr, u0_wr} = {u, ~u};
      sy(1);
      {u1_wr, u0_wr} = 2'b00;
      sy(1);
   endtask : prog
   task automatic hit(input logic d, input logic [31:0] a, input logic wr, input logic uw,
                      input logic [2:0] e, input logic [2:0] m);
      r = nxt(r);
      seen = 3'b000;
      if (d) dacc = '{addr: a, user: r[0], write: wr, size: r[2:1], ext_cond: r[3]};
      else iacc = '{addr: a, user: r[0], write: wr, size: r[2:1], ext_cond: r[3]};
      {dvalid, ivalid, u0_wr} = {d, ~d, uw};
      sy(1);
      {dvalid, ivalid, u0_wr} = 3'b000;
      sy(4);
      chk_word("halt_dabort_pabort", {29'h0, e & m}, {29'h0, seen & m});
   endtask : hit
   // =====================================
   // main sequence
   initial begin
      r = 32'h7c310ce8;
      sy(16);
      rst = 1'b0;
      sy(2);
      chk_word("cp_status", {`DCM_VERSION, 28'h0}, cp_status);
      chk_word("jt_status", 32'h0, {30'h0, jt_status});
      $display("reset test done");
      slow = 1'b1;
      for (k = 0; k < 5; k++) begin
         r = nxt(r);
         w = r;
         rx_exp = rx_count + 16'h1;
         out_wr = 1'b1;
         out_data = w;
         sy(1);
         out_wr = 1'b0;
         out_data = ~w;
         sy(1);
         chk_bit("out_pending", 1'b1, cp_status[1]);
         wait_for(3, 1'b1);
         if (k == 0) begin
            out_wr = 1'b1;
            out_data = nxt(r);
            sy(1);
            out_wr = 1'b0;
            sy(4);
         end
         slow = 1'b0;
         wait_for(5, 1'b1);
         chk_word("out_word", w, rx_word);
         wait_for(1, 1'b0);
         sy(40);
         chk_word("out_count", {16'h0, rx_exp}, {16'h0, rx_count});
      end
      $display("outbound test done");
      for (k = 0; k < 4; k++) begin
         r = nxt(r);
         w = r;
         send_word = w;
         send_tog = ~send_tog;
         wait_for(0, 1'b1);
         wait_for(2, 1'b1);
         sy(1);
         chk_word("in_word", w, in_data);
         in_rd = 1'b1;
         sy(1);
         in_rd = 1'b0;
         wait_for(0, 1'b0);
         wait_for(2, 1'b0);
      end
      $display("inbound test done");
      for (k = 0; k < 3; k++) begin
         pins = 3'b001 << k;
         seen = 3'b000;
         sy(8);
         pins = 3'b000;
         sy(2);
         chk_bit("halt_mode_pin", 1'b1, seen[2]);
      end
      @(posedge link_clk);
      #1;
      {ctrl_wr, ctrl_d} = {1'b1, 6'h10};
      @(posedge link_clk);
      #1;
      ctrl_wr = 1'b0;
      wait_for(4, 1'b1);
      ba = nxt(r);
      wa = nxt(ba);
      r = wa;
      c = '{enable: 1'b0, is_watch: 1'b0, addr: ba, default: '0};
      prog(1'b0, c);
      c.enable = 1'b1;
      prog(1'b0, c);
      c = '{is_watch: 1'b1, addr: wa, care_write: 1'b1, match_write: 1'b1, default: '0};
      prog(1'b1, c);
      c.enable = 1'b1;
      prog(1'b1, c);
      hit(1'b0, ba, 1'b0, 1'b0, 3'b001, 3'b111);
      chk_bit("abort_flag", 1'b1, abt_flag);
      hit(1'b0, ba ^ 32'h10, 1'b0, 1'b0, 3'b000, 3'b111);
      hit(1'b1, wa, 1'b1, 1'b0, 3'b010, 3'b111);
      hit(1'b1, wa, 1'b0, 1'b0, 3'b000, 3'b111);
      hit(1'b0, ba, 1'b0, 1'b1, 3'b000, 3'b111);
      {st_wr, st_d} = 2'b10;
      sy(1);
      st_wr = 1'b0;
      sy(2);
      chk_bit("abort_flag", 1'b0, abt_flag);
      ext_abt = 1'b1;
      hit(1'b1, wa, 1'b1, 1'b0, 3'b000, 3'b100);
      ext_abt = 1'b0;
      chk_bit("abort_flag", 1'b0, abt_flag);
      pins = 3'b111;
      seen = 3'b000;
      sy(8);
      pins = 3'b000;
      chk_bit("monitor_pins", 1'b0, seen[2]);
      $display("monitor test done");
      complete_run();
   end
endmodule : dcm_debug_comms_monitor_tb_top
